/* File: common/msw_pkg.sv */
// Constants and types shared by the microstep wave table design.
package msw_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LUT0  = 8'h00;
  localparam logic [7:0] OFS_LUT7  = 8'h1C;
  localparam logic [7:0] OFS_SEG   = 8'h20;
  localparam logic [7:0] OFS_START = 8'h24;
  localparam logic [7:0] OFS_CUR   = 8'h28;
  localparam logic [7:0] OFS_POS   = 8'h2C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SEG_W_LSB   = 0;
  localparam int SEG_X1_LSB  = 8;
  localparam int SEG_X2_LSB  = 16;
  localparam int SEG_X3_LSB  = 24;
  localparam int START_A_LSB = 0;
  localparam int START_B_LSB = 16;
  localparam int COIL_A_CURRENT_VALUE_LSB   = 0;
  localparam int COIL_B_CURRENT_VALUE_LSB   = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  // Default sine quarter wave, increment bit 0 in bit 0 of word 0.
  localparam logic [255:0] LUT_RST = {
    32'h0040_4222, 32'h4929_5556, 32'hB5BB_777D, 32'hFBFF_FFFF,
    32'h1010_4222, 32'h2449_2929, 32'h4A95_54AA, 32'hAAAA_B554};
  localparam logic [31:0] SEG_RST   = 32'hFFFF_8056;
  localparam logic [31:0] START_RST = 32'h00F7_0000;

  // ---------------------------------------------------------------
  // Position constants and types
  // ---------------------------------------------------------------
  localparam logic [9:0] POS_ONE     = 10'h001;
  localparam logic [9:0] POS_LAST    = 10'h3FF;
  localparam logic [9:0] POS_QUARTER = 10'h100;

  typedef logic [9:0]        msw_pos_t;
  typedef logic signed [9:0] msw_mag_t;
  typedef logic signed [2:0] msw_dlt_t;
  typedef logic [8:0]        msw_cur_t;

endpackage

/* File: dv/msw_table_tb.sv */
// Self-checking testbench for the microstep wave table.
`timescale 1ns/10ps
module testbench;
  import msw_pkg::*;

  // ---------------------------------------------------------------
  // Stimulus, observed outputs and reference state
  // ---------------------------------------------------------------
  logic         clk;
  logic         rst;
  logic [7:0]   addr;
  logic [31:0]  wdata;
  logic         wr;
  logic         rd;
  logic [31:0]  rdata;
  logic         step;
  logic         dir;
  msw_cur_t     coil_a_current_value;
  msw_cur_t     coil_b_current_value;
  msw_pos_t     pos_o;
  int           err_count;
  int           cmp_count;
  logic [255:0] lut;
  logic [31:0]  seg;
  int           sa;
  int           sb;
  int           pos;
  int           ma;
  int           mb;

  msw_table u_msw_table (
    .CLK_I                        (clk),
    .RST_I                        (rst),
    .ADDR_I                       (addr),
    .WDATA_I                      (wdata),
    .WR_I                         (wr),
    .RD_I                         (rd),
    .RDATA_O                      (rdata),
    .STEP_I                       (step),
    .DIR_I                        (dir),
    .COIL_A_CURRENT_VALUE_O       (coil_a_current_value),
    .COIL_B_CURRENT_VALUE_O       (coil_b_current_value),
    .MICROSTEP_POSITION_COUNTER_O (pos_o)
  );

  // Free-running clock with a 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A write also updates the reference copy, so later steps follow it.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a <= OFS_LUT7 && a[1:0] == 2'b00) lut[a[4:2] * 32 +: 32] = d;
    if (a == OFS_SEG) seg = d;
    if (a == OFS_START) begin
      sa = int'(d[7:0]);
      sb = int'(d[23:16]);
    end
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // Write then read the same word back to back; the new value must show.
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, d);
  endtask

  // ---------------------------------------------------------------
  // Reference wave model
  // ---------------------------------------------------------------
  function automatic int dlt(input int i);
    int s;
    s = (i < int'(seg[15:8])) ? 0 : (i < int'(seg[23:16])) ? 1 :
        (i < int'(seg[31:24])) ? 2 : 3;
    return int'(seg[2 * s +: 2]) - 1 + int'(lut[i]);
  endfunction

  // Odd quadrants walk the quarter table backward; down reverses sense.
  function automatic int mstep(input int ph, input logic dn, input int m);
    int q;
    int inc;
    q   = dn ? (ph + 1023) % 1024 : ph;
    inc = q[8] ? -dlt(255 - q % 256) : dlt(q % 256);
    return dn ? m - inc : m + inc;
  endfunction

  function automatic logic [31:0] cur(input int m, input logic neg);
    int v;
    v = neg ? -m : m;
    return 32'(v[8:0]);
  endfunction

  // Steps every cycle and compares both coils after each one.
  task automatic sweep(input logic dn, input int n);
    @(posedge clk);
    step <= 1'b1;
    dir  <= dn;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      if (k == n - 1) step <= 1'b0;
      #1;
      ma  = mstep(pos, dn, ma);
      mb  = mstep((pos + 256) % 1024, dn, mb);
      pos = (pos + (dn ? 1023 : 1)) % 1024;
      if (pos == 0) begin
        ma = sa;
        mb = sb;
      end
      check(32'(pos_o), pos);
      check(32'(coil_a_current_value), cur(ma, pos >= 256 && pos < 768));
      check(32'(coil_b_current_value), cur(mb, pos >= 512));
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    for (int n = 0; n < 8; n++) begin
      rd_chk(8'(4 * n), LUT_RST[32 * n +: 32]);
    end
    rd_chk(OFS_SEG, SEG_RST);
    rd_chk(OFS_START, START_RST);
    rd_chk(OFS_CUR, START_RST);
    rd_chk(OFS_POS, 32'h0000_0000);
    rd_chk(8'h30, 32'h0000_0000);
  endtask

  // New start values only take effect when the counter passes zero.
  task automatic test_up();
    sweep(1'b0, 600);
    wr_reg(OFS_START, 32'h00F0_0003);
    sweep(1'b0, 424);
  endtask

  // The custom wave rises from its start value and peaks at 247, so the
  // swing keeps the chopper headroom and the start values fit the wave.
  task automatic test_regs();
    wr_reg(OFS_SEG, 32'hF05D_201B);
    wr_reg(8'h21, 32'h0000_0000);
    rd_chk(OFS_SEG, 32'hF05D_201B);
    wr_rd(OFS_LUT0, 32'h0F0F_0F0F);
    for (int n = 0; n < 8; n++) begin
      wr_reg(8'(4 * n), 32'h5555_5555);
    end
    rd_chk(OFS_LUT7, 32'h5555_5555);
    wr_reg(OFS_CUR, 32'hFFFF_FFFF);
    rd_chk(OFS_CUR, 32'h00F0_0003);
    wr_rd(OFS_START, 32'h00EF_0002);
    sa = 2;
    sb = 239;
  endtask

  // Custom slopes -1, 0, 1 and 2 down a full turn, then reversals at zero and at position 2.
  task automatic test_down();
    sweep(1'b1, 1024);
    sweep(1'b0, 2);
    sweep(1'b1, 4);
  endtask

  // A second reset mid-run restores table, words, position and coils.
  task automatic test_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_reset();
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst       = 1'b1;
    addr      = 8'h00;
    wdata     = 32'h0000_0000;
    wr        = 1'b0;
    rd        = 1'b0;
    step      = 1'b0;
    dir       = 1'b0;
    err_count = 0;
    cmp_count = 0;
    lut       = LUT_RST;
    seg       = SEG_RST;
    sa        = 0;
    sb        = 247;
    pos       = 0;
    ma        = 0;
    mb        = 247;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_up();
    test_regs();
    test_down();
    test_rerst();
    end_sim();
  end

  // A hang counts as a mismatch and ends the run.
  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule

/* File: rtl/msw_seg.sv */
// Increment lookup: segment slope plus table bit for one table index.
`timescale 1ns/10ps
module msw_seg (
  // Table index and configuration
  input  wire logic [7:0]       idx_i,
  input  wire logic [255:0]     lut_i,
  input  wire logic [31:0]      seg_i,
  // Signed increment, -1 to 3
  output msw_pkg::msw_dlt_t     delta_o
);
  import msw_pkg::*;

  logic [1:0] code;

  // Pick the segment from the three boundaries, then add the bit.
  always_comb begin
    if (idx_i < seg_i[SEG_X1_LSB +: 8]) begin
      code = seg_i[SEG_W_LSB +: 2];
    end else if (idx_i < seg_i[SEG_X2_LSB +: 8]) begin
      code = seg_i[SEG_W_LSB + 2 +: 2];
    end else if (idx_i < seg_i[SEG_X3_LSB +: 8]) begin
      code = seg_i[SEG_W_LSB + 4 +: 2];
    end else begin
      code = seg_i[SEG_W_LSB + 6 +: 2];
    end
    // Codes 0..3 mean base slopes -1..2; a set bit adds one.
    delta_o = $signed({1'b0, code}) - 3'sd1
            + $signed({2'b00, lut_i[idx_i]});
  end

endmodule

/* File: rtl/msw_step.sv */
// One microstep move of a mirrored quarter wave magnitude.
`timescale 1ns/10ps
module msw_step (
  // Wave phase before the move and direction
  input  msw_pkg::msw_pos_t  phase_i,
  input  wire logic          dir_dn_i,
  // Present magnitude and increment for idx_o
  input  msw_pkg::msw_mag_t  mag_i,
  input  msw_pkg::msw_dlt_t  delta_i,
  // Table index used and magnitude after the move
  output logic [7:0]         idx_o,
  output msw_pkg::msw_mag_t  mag_o
);
  import msw_pkg::*;

  msw_pos_t prev;
  logic     grow;

  // Odd quadrants walk the table backward; even ones forward.
  always_comb begin
    prev = phase_i - POS_ONE;
    if (!dir_dn_i) begin
      idx_o = phase_i[8] ? ~phase_i[7:0] : phase_i[7:0];
      grow  = !phase_i[8];
    end else begin
      idx_o = prev[8] ? ~prev[7:0] : prev[7:0];
      grow  = prev[8];
    end
    if (grow) begin
      mag_o = mag_i + {{7{delta_i[2]}}, delta_i};
    end else begin
      mag_o = mag_i - {{7{delta_i[2]}}, delta_i};
    end
  end

endmodule

/* File: rtl/msw_table.sv */
// Microstep wave table with position counter and coil current outputs.
`timescale 1ns/10ps
// What this block does
// - A quarter wave is kept as 256 increment bits in eight 32-bit words.
// - The 10-bit position counter walks the wave mirrored over 360 degrees.
// - Each microstep adds the segment base slope, plus one if the bit is 1.
// - Every base slope field selects -1, 0, 1 or 2.
// - Three boundaries split the quarter wave into four slope segments.
// - Every microstep updates both coil current values.
// - Passing position zero reloads both coils from absolute start values.
// - The first coil starts from a programmable value at position zero.
// - The second coil has its own programmable start value.
// - Reset loads the default sine table and segment word 0xFFFF8056.
// - Reset loads the start values word 0x00F70000.
// - Coil A is negative for 256..767, coil B negative for 512..1023.
module msw_table (
  // Clock and reset
  input  wire logic         CLK_I,
  input  wire logic         RST_I,
  // Register port
  input  wire logic [7:0]   ADDR_I,
  input  wire logic [31:0]  WDATA_I,
  input  wire logic         WR_I,
  input  wire logic         RD_I,
  output logic [31:0]       RDATA_O,
  // Microstep advance from the sequencer
  input  wire logic         STEP_I,
  input  wire logic         DIR_I,
  // Coil currents and position
  output msw_pkg::msw_cur_t COIL_A_CURRENT_VALUE_O,
  output msw_pkg::msw_cur_t COIL_B_CURRENT_VALUE_O,
  output msw_pkg::msw_pos_t MICROSTEP_POSITION_COUNTER_O
);
  import msw_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [255:0] lut;
    logic [31:0]  seg;
    logic [31:0]  start;
    msw_pos_t     pos;
    msw_mag_t     mag_a;
    msw_mag_t     mag_b;
    msw_cur_t     coil_a_current_value;
    msw_cur_t     coil_b_current_value;
    logic [31:0]  rdata;
  } msw_state_t;

  msw_state_t state_reg;
  msw_state_t state_next;

  // ---------------------------------------------------------------
  // Decode and stepping helpers
  // ---------------------------------------------------------------
  logic       is_lut;
  logic [7:0] lut_sel;
  logic [31:0] rd_word;
  msw_pos_t   pos_adv;
  msw_pos_t   phase_b;
  logic [7:0] idx_a;
  logic [7:0] idx_b;
  msw_dlt_t   delta_a;
  msw_dlt_t   delta_b;
  msw_mag_t   step_a;
  msw_mag_t   step_b;
  msw_mag_t   start_a;
  msw_mag_t   start_b;

  // Table words sit at aligned offsets 0x00..0x1C.
  assign is_lut  = (ADDR_I <= OFS_LUT7) && (ADDR_I[1:0] == 2'b00);
  assign lut_sel = {ADDR_I[4:2], 5'h00};

  // STEP_I and DIR_I come from same-clock sequencer logic.
  // High DIR_I steps down.
  assign pos_adv = DIR_I ? state_reg.pos - POS_ONE
                         : state_reg.pos + POS_ONE;
  assign phase_b = state_reg.pos + POS_QUARTER;

  // Start values are unsigned bytes of the start word.
  assign start_a = $signed({2'b00, state_reg.start[START_A_LSB +: 8]});
  assign start_b = $signed({2'b00, state_reg.start[START_B_LSB +: 8]});

  // ---------------------------------------------------------------
  // Wave walkers for both coils
  // ---------------------------------------------------------------
  // Both coils share one table; only the phase differs.
  msw_seg u_seg_a (
    .idx_i   (idx_a),
    .lut_i   (state_reg.lut),
    .seg_i   (state_reg.seg),
    .delta_o (delta_a)
  );

  msw_seg u_seg_b (
    .idx_i   (idx_b),
    .lut_i   (state_reg.lut),
    .seg_i   (state_reg.seg),
    .delta_o (delta_b)
  );

  msw_step u_step_a (
    .phase_i  (state_reg.pos),
    .dir_dn_i (DIR_I),
    .mag_i    (state_reg.mag_a),
    .delta_i  (delta_a),
    .idx_o    (idx_a),
    .mag_o    (step_a)
  );

  msw_step u_step_b (
    .phase_i  (phase_b),
    .dir_dn_i (DIR_I),
    .mag_i    (state_reg.mag_b),
    .delta_i  (delta_b),
    .idx_o    (idx_b),
    .mag_o    (step_b)
  );

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  // Unmapped and misaligned addresses read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_lut) begin
      rd_word = state_reg.lut[lut_sel +: 32];
    end else begin
      case (ADDR_I)
        OFS_SEG: begin
          rd_word = state_reg.seg;
        end
        OFS_START: begin
          rd_word = state_reg.start;
        end
        OFS_CUR: begin
          rd_word[COIL_A_CURRENT_VALUE_LSB +: 9] = state_reg.coil_a_current_value;
          rd_word[COIL_B_CURRENT_VALUE_LSB +: 9] = state_reg.coil_b_current_value;
        end
        OFS_POS: begin
          rd_word[9:0] = state_reg.pos;
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // A table write takes effect on the very next step, so software
  // should rewrite a live table only near a zero pass.
  always_comb begin
    state_next       = state_reg;
    state_next.rdata = 32'h0000_0000;
    if (WR_I) begin
      if (is_lut) begin
        state_next.lut[lut_sel +: 32] = WDATA_I;
      end else if (ADDR_I == OFS_SEG) begin
        state_next.seg = WDATA_I;
      end else if (ADDR_I == OFS_START) begin
        state_next.start = WDATA_I;
      end
    end
    if (RD_I) begin
      state_next.rdata = rd_word;
    end
    if (STEP_I) begin
      state_next.pos = pos_adv;
      if (pos_adv == 10'h000) begin
        // Absolute reload flushes any drift of the incremental sum.
        state_next.mag_a = start_a;
        state_next.mag_b = start_b;
      end else begin
        state_next.mag_a = step_a;
        state_next.mag_b = step_b;
      end
    end
    // Sign follows the position of the counter after the move.
    if (state_next.pos[9] ^ state_next.pos[8]) begin
      state_next.coil_a_current_value = 9'(-state_next.mag_a);
    end else begin
      state_next.coil_a_current_value = state_next.mag_a[8:0];
    end
    if (state_next.pos[9]) begin
      state_next.coil_b_current_value = 9'(-state_next.mag_b);
    end else begin
      state_next.coil_b_current_value = state_next.mag_b[8:0];
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg.lut   <= LUT_RST;
      state_reg.seg   <= SEG_RST;
      state_reg.start <= START_RST;
      state_reg.pos   <= 10'h000;
      state_reg.mag_a <= $signed({2'b00, START_RST[START_A_LSB +: 8]});
      state_reg.mag_b <= $signed({2'b00, START_RST[START_B_LSB +: 8]});
      state_reg.coil_a_current_value <= {1'b0, START_RST[START_A_LSB +: 8]};
      state_reg.coil_b_current_value <= {1'b0, START_RST[START_B_LSB +: 8]};
      state_reg.rdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a field of the state register.
  assign RDATA_O                      = state_reg.rdata;
  assign COIL_A_CURRENT_VALUE_O       = state_reg.coil_a_current_value;
  assign COIL_B_CURRENT_VALUE_O       = state_reg.coil_b_current_value;
  assign MICROSTEP_POSITION_COUNTER_O = state_reg.pos;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  // Step up inside the first quadrant, away from a zero pass.
  sequence s_up_q0;
    STEP_I && !DIR_I && !state_reg.pos[8] && !state_reg.pos[9];
  endsequence

  // Step down landing in an odd quadrant, away from a zero pass.
  sequence s_dn_odd;
    STEP_I && DIR_I && pos_adv[8] && (state_reg.pos != POS_ONE);
  endsequence

  // Counter steps onto zero in either direction.
  sequence s_zero_pass;
    STEP_I && ((!DIR_I && state_reg.pos == POS_LAST)
            || (DIR_I && state_reg.pos == POS_ONE));
  endsequence

  // Table word write followed by a read of the same word.
  sequence s_lut_wr_rd;
    (WR_I && is_lut) ##1 (RD_I && is_lut && $stable(ADDR_I));
  endsequence

  // Step down landing in an even quadrant, away from a zero pass.
  sequence s_dn_even;
    STEP_I && DIR_I && !pos_adv[8] && (state_reg.pos != POS_ONE);
  endsequence

  // Step up inside an odd quadrant, away from a zero pass.
  sequence s_up_odd;
    STEP_I && !DIR_I && state_reg.pos[8] && (state_reg.pos != POS_LAST);
  endsequence

  AST_LUT_READBACK:
    assert property (s_lut_wr_rd |=> RDATA_O == $past(WDATA_I, 2))
    else $error("table word did not read back as written");

  AST_POS_UP:
    assert property (STEP_I && !DIR_I |=>
      state_reg.pos == $past(state_reg.pos) + POS_ONE)
    else $error("position did not advance by one");

  AST_UP_DELTA:
    assert property (s_up_q0 |=>
      state_reg.mag_a == $past(state_reg.mag_a)
                       + {{7{$past(delta_a[2])}}, $past(delta_a)})
    else $error("coil A did not add the increment");

  AST_DN_MIRROR:
    assert property (s_dn_odd |=>
      state_reg.mag_a == $past(state_reg.mag_a)
                       + {{7{$past(delta_a[2])}}, $past(delta_a)})
    else $error("backward quadrant step used the wrong sense");

  AST_HOLD:
    assert property (!STEP_I |=>
      $stable(state_reg.coil_a_current_value) && $stable(state_reg.coil_b_current_value)
      && $stable(state_reg.pos))
    else $error("coil values moved without a microstep");

  AST_ZERO_A:
    assert property (s_zero_pass |=>
      state_reg.mag_a == $signed({2'b00,
        $past(state_reg.start[START_A_LSB +: 8])}))
    else $error("coil A not reloaded at zero pass");

  AST_ZERO_B:
    assert property (s_zero_pass |=>
      state_reg.mag_b == $signed({2'b00,
        $past(state_reg.start[START_B_LSB +: 8])}))
    else $error("coil B not reloaded at zero pass");

  AST_SIGN_A:
    assert property ((state_reg.pos[9] ^ state_reg.pos[8]) |->
      state_reg.coil_a_current_value == 9'(-state_reg.mag_a))
    else $error("coil A sign wrong for position");

  AST_SIGN_B:
    assert property (!state_reg.pos[9] |->
      state_reg.coil_b_current_value == state_reg.mag_b[8:0])
    else $error("coil B sign wrong for position");

  AST_B_OFFSET:
    assert property (STEP_I && !DIR_I |->
      idx_b == (state_reg.pos[8] ? state_reg.pos[7:0]
                                 : ~state_reg.pos[7:0]))
    else $error("coil B not a quarter period ahead");

  AST_POS_DN:
    assert property (STEP_I && DIR_I |=>
      state_reg.pos == $past(state_reg.pos) - POS_ONE)
    else $error("position did not step back by one");

  AST_DN_DELTA:
    assert property (s_dn_even |=>
      state_reg.mag_a == $past(state_reg.mag_a)
                       - {{7{$past(delta_a[2])}}, $past(delta_a)})
    else $error("coil A did not take off the increment");

  AST_UP_MIRROR:
    assert property (s_up_odd |=>
      state_reg.mag_a == $past(state_reg.mag_a)
                       - {{7{$past(delta_a[2])}}, $past(delta_a)})
    else $error("forward odd quadrant step used the wrong sense");

  AST_COIL_A_CURRENT_VALUE_START:
    assert property (s_zero_pass |=>
      COIL_A_CURRENT_VALUE_O == {1'b0,
        $past(state_reg.start[START_A_LSB +: 8])})
    else $error("coil A output not restarted at zero pass");

  AST_COIL_B_CURRENT_VALUE_START:
    assert property (s_zero_pass |=>
      COIL_B_CURRENT_VALUE_O == {1'b0,
        $past(state_reg.start[START_B_LSB +: 8])})
    else $error("coil B output not restarted at zero pass");

  AST_SIGN_A_POS:
    assert property (!(state_reg.pos[9] ^ state_reg.pos[8]) |->
      state_reg.coil_a_current_value == state_reg.mag_a[8:0])
    else $error("coil A negated outside its negative zone");

  AST_SIGN_B_NEG:
    assert property (state_reg.pos[9] |->
      state_reg.coil_b_current_value == 9'(-state_reg.mag_b))
    else $error("coil B not negated in its negative zone");

endmodule
